// ===== logic/fuse_cfg_defines.vh
// constants for the fuse, identity and trim configuration block
`ifndef FUSE_CFG_DEFINES_VH
`define FUSE_CFG_DEFINES_VH
`define EXT_FUSE_RESET 8'hff
`define HIGH_FUSE_RESET 8'hdf
`define LOW_FUSE_RESET 8'h62
`define EXT_USED_MASK 8'h01
`define EXT_UNUSED_ONES 8'hfe
`define SELF_WRITE_BIT 0
`define RESET_PIN_OFF_BIT 7
`define DEBUG_LINK_BIT 6
`define SERIAL_PROG_BIT 5
`define WATCHDOG_BIT 4
`define EEPROM_KEEP_BIT 3
`define BROWNOUT_MSB 2
`define CLOCK_DIV_BIT 7
`define CLOCK_OUT_BIT 6
`define STARTUP_MSB 5
`define STARTUP_LSB 4
`define CLOCK_SRC_MSB 3
`define SEL_EXT 2'h0
`define SEL_HIGH 2'h1
`define SEL_LOW 2'h2
`define SEL_LOCK 2'h3
`define ID_ADDR_0 2'h0
`define ID_ADDR_1 2'h1
`define ID_ADDR_2 2'h2
`define ERASED_BYTE 8'hff
`define LOCK_RESET 2'h3
`define LOCK_ONE_BIT 0
`define LOCK_PAD_ONES 6'h3f
`define ID_RESET_BYTE 8'h00
`define FUSE_BITS 8
`define EE_WORD_MSB 1
`endif

// ===== logic/fuse_signature_config.v
// fuse storage, latching, identity and trim loading, page address split
`timescale 1ns/1ns
`include "fuse_cfg_defines.vh"
module fuse_signature_config #(
	parameter [7:0] ID_BYTE_0 = 8'h5a, // arbitrary value
	parameter [7:0] ID_BYTE_1 = 8'h01, // arbitrary value
	parameter [7:0] ID_BYTE_2 = 8'h02, // arbitrary value
	parameter [7:0] TRIM_BYTE = 8'h80,
	parameter FLASH_WORD_BITS = 5,
	parameter PC_TOP = 11,
	parameter EE_TOP = 8
) (
	input wire clk_i,
	input wire reset_n_i,
	input wire prog_mode_i,
	input wire serial_port_i,
	input wire fuse_write_i,
	input wire [1:0] fuse_sel_i,
	input wire [7:0] fuse_data_i,
	input wire lock_write_i,
	input wire [1:0] lock_data_i,
	input wire chip_erase_i,
	input wire [1:0] read_sel_i,
	input wire id_read_i,
	input wire [1:0] id_addr_i,
	input wire [PC_TOP:0] prog_counter_i,
	input wire [EE_TOP:0] eeprom_byte_address_i,
	output reg [7:0] read_data_o,
	output reg [7:0] id_data_o,
	output reg [7:0] oscillator_trim_register_o,
	output wire [7:0] extended_config_fuses_o,
	output wire [7:0] high_config_fuses_o,
	output wire [7:0] low_config_fuses_o,
	output wire self_write_allow_o,
	output wire reset_pin_off_o,
	output wire debug_link_on_o,
	output wire serial_prog_allow_o,
	output wire watchdog_forced_on_o,
	output wire watchdog_irq_allow_o,
	output wire eeprom_keep_on_erase_o,
	output wire [2:0] brownout_threshold_o,
	output wire clock_divide_eight_o,
	output wire clock_pin_output_o,
	output wire clock_pin_o,
	output wire [1:0] startup_delay_select_o,
	output wire [3:0] clock_source_select_o,
	output wire erase_eeprom_o,
	output wire erase_flash_o,
	output wire [7:0] erase_fill_o,
	output wire [FLASH_WORD_BITS-1:0] word_in_page_index_o,
	output wire [PC_TOP-FLASH_WORD_BITS:0] page_index_o,
	output wire [`EE_WORD_MSB:0] eeprom_word_index_o,
	output wire [EE_TOP-`EE_WORD_MSB-1:0] eeprom_page_index_o
);
	// nonvolatile images, 0 = programmed
	reg [7:0] ext_store;
	reg [7:0] high_store;
	reg [7:0] low_store;
	reg [1:0] lock_store;
	// active copies seen by the rest of the chip
	reg [7:0] ext_active;
	reg [7:0] high_active;
	reg [7:0] low_active;
	reg prog_mode_d;
	// power-on marker; later resets must keep nonvolatile state
	reg por_done = 1'b0;
	reg [7:0] next_ext_store;
	reg [7:0] next_high_store;
	reg [7:0] next_low_store;
	reg [1:0] next_lock_store;
	reg [7:0] next_ext_active;
	reg [7:0] next_high_active;
	reg [7:0] next_low_active;
	reg [7:0] next_read_data;
	reg [7:0] next_id_data;
	reg [7:0] next_high;
	wire power_up;
	wire fuse_allow;
	wire erase_ok;
	wire lock_write_ok;
	wire fuse_write_ok;
	wire leaving_prog;
	wire entering_prog;
	wire latch_now;
	wire eeprom_spared;
	wire [7:0] ext_programmed;
	wire [7:0] high_programmed;
	wire [7:0] low_programmed;
	genvar bit_idx;

	assign power_up = ~reset_n_i & ~por_done;
	assign fuse_allow = lock_store[`LOCK_ONE_BIT];
	// priority: erase, then lock write, then fuse write
	assign erase_ok = prog_mode_i & chip_erase_i;
	assign lock_write_ok = prog_mode_i & lock_write_i & ~chip_erase_i;
	assign fuse_write_ok = prog_mode_i & fuse_write_i & ~chip_erase_i & ~lock_write_i & fuse_allow;
	assign entering_prog = prog_mode_i & ~prog_mode_d;
	assign leaving_prog = ~prog_mode_i & prog_mode_d;
	assign latch_now = entering_prog | leaving_prog;

	always @*
	begin
		next_high = fuse_data_i;
		if (serial_port_i)
		begin
			next_high[`SERIAL_PROG_BIT] = high_store[`SERIAL_PROG_BIT];
		end
	end

	always @(posedge clk_i)
	begin
		if (!reset_n_i)
		begin
			por_done <= 1'b1;
		end
	end

	// lock bits only ever clear, except through erase
	always @*
	begin
		next_lock_store = lock_store;
		if (erase_ok)
		begin
			next_lock_store = `LOCK_RESET;
		end
		else if (lock_write_ok)
		begin
			next_lock_store = lock_store & lock_data_i;
		end
	end

	// chip erase touches lock bits only, never the fuse images
	always @*
	begin
		next_ext_store = ext_store;
		next_high_store = high_store;
		next_low_store = low_store;
		if (fuse_write_ok)
		begin
			case (fuse_sel_i)
			`SEL_EXT:
			begin
				next_ext_store = fuse_data_i | `EXT_UNUSED_ONES;
			end
			`SEL_HIGH:
			begin
				next_high_store = next_high;
			end
			`SEL_LOW:
			begin
				next_low_store = fuse_data_i;
			end
			default:
			begin
				next_low_store = low_store;
			end
			endcase
		end
	end

	always @(posedge clk_i)
	begin
		if (power_up)
		begin
			ext_store <= `EXT_FUSE_RESET;
			high_store <= `HIGH_FUSE_RESET;
			low_store <= `LOW_FUSE_RESET;
			lock_store <= `LOCK_RESET;
		end
		else
		begin
			ext_store <= next_ext_store;
			high_store <= next_high_store;
			low_store <= next_low_store;
			lock_store <= next_lock_store;
		end
	end

	// power-up latch, entry latch, then apply on exit
	always @*
	begin
		next_ext_active = ext_active;
		next_high_active = high_active;
		next_low_active = low_active;
		if (latch_now)
		begin
			next_ext_active = ext_store;
			next_high_active = high_store;
			next_low_active = low_store;
		end
		else
		begin
			// eeprom keep bypasses the latch
			next_high_active[`EEPROM_KEEP_BIT] = high_store[`EEPROM_KEEP_BIT];
		end
	end

	always @(posedge clk_i)
	begin
		if (power_up)
		begin
			ext_active <= `EXT_FUSE_RESET;
			high_active <= `HIGH_FUSE_RESET;
			low_active <= `LOW_FUSE_RESET;
			prog_mode_d <= 1'b0;
		end
		else
		begin
			ext_active <= next_ext_active;
			high_active <= next_high_active;
			low_active <= next_low_active;
			prog_mode_d <= prog_mode_i;
		end
	end

	// trim reload happens on every reset, not only power-up
	always @(posedge clk_i)
	begin
		if (!reset_n_i)
		begin
			oscillator_trim_register_o <= TRIM_BYTE;
		end
	end

	always @*
	begin
		next_read_data = read_data_o;
		case (read_sel_i)
		`SEL_EXT:
		begin
			next_read_data = ext_store;
		end
		`SEL_HIGH:
		begin
			next_read_data = high_store;
		end
		`SEL_LOW:
		begin
			next_read_data = low_store;
		end
		`SEL_LOCK:
		begin
			next_read_data = {`LOCK_PAD_ONES, lock_store};
		end
		default:
		begin
			next_read_data = `ERASED_BYTE;
		end
		endcase
	end

	// identity stays readable regardless of lock state
	always @*
	begin
		next_id_data = id_data_o;
		if (id_read_i)
		begin
			case (id_addr_i)
			`ID_ADDR_0:
			begin
				next_id_data = ID_BYTE_0;
			end
			`ID_ADDR_1:
			begin
				next_id_data = ID_BYTE_1;
			end
			`ID_ADDR_2:
			begin
				next_id_data = ID_BYTE_2;
			end
			default:
			begin
				next_id_data = `ERASED_BYTE;
			end
			endcase
		end
	end

	always @(posedge clk_i)
	begin
		if (!reset_n_i)
		begin
			read_data_o <= `ERASED_BYTE;
			id_data_o <= `ID_RESET_BYTE;
		end
		else
		begin
			read_data_o <= next_read_data;
			id_data_o <= next_id_data;
		end
	end

	// per-bit polarity flip: a programmed fuse reads zero
	generate
		for (bit_idx = 0; bit_idx < `FUSE_BITS; bit_idx = bit_idx + 1)
		begin : g_programmed
			assign ext_programmed[bit_idx] = ~ext_active[bit_idx];
			assign high_programmed[bit_idx] = ~high_active[bit_idx];
			assign low_programmed[bit_idx] = ~low_active[bit_idx];
		end
	endgenerate

	assign extended_config_fuses_o = ext_active;
	assign high_config_fuses_o = high_active;
	assign low_config_fuses_o = low_active;

	assign self_write_allow_o = ext_programmed[`SELF_WRITE_BIT];

	assign reset_pin_off_o = high_programmed[`RESET_PIN_OFF_BIT];
	assign debug_link_on_o = high_programmed[`DEBUG_LINK_BIT];
	assign serial_prog_allow_o = high_programmed[`SERIAL_PROG_BIT];
	assign watchdog_forced_on_o = high_programmed[`WATCHDOG_BIT];
	assign watchdog_irq_allow_o = ~high_programmed[`WATCHDOG_BIT];
	assign eeprom_keep_on_erase_o = high_programmed[`EEPROM_KEEP_BIT];
	assign brownout_threshold_o = high_active[`BROWNOUT_MSB:0];

	assign clock_divide_eight_o = low_programmed[`CLOCK_DIV_BIT];
	assign clock_pin_output_o = low_programmed[`CLOCK_OUT_BIT];
	assign startup_delay_select_o = low_active[`STARTUP_MSB:`STARTUP_LSB];
	assign clock_source_select_o = low_active[`CLOCK_SRC_MSB:0];

	// gated clock passes straight to the pin buffer; not glitch-free, since
	// the enable changes on the rising edge while clk_i is high
	assign clock_pin_o = clock_pin_output_o & clk_i;

	// eeprom erase follows the live keep bit, not the latched byte
	assign eeprom_spared = high_programmed[`EEPROM_KEEP_BIT];
	assign erase_flash_o = erase_ok;
	assign erase_eeprom_o = erase_ok & ~eeprom_spared;
	assign erase_fill_o = `ERASED_BYTE;

	assign word_in_page_index_o = prog_counter_i[FLASH_WORD_BITS-1:0];
	assign page_index_o = prog_counter_i[PC_TOP:FLASH_WORD_BITS];
	assign eeprom_word_index_o = eeprom_byte_address_i[`EE_WORD_MSB:0];
	assign eeprom_page_index_o = eeprom_byte_address_i[EE_TOP:`EE_WORD_MSB+1];
endmodule // fuse_signature_config

// ===== bench/fuse_prog_model.sv
// programmer model driving the configuration side of the block
`timescale 1ns/1ns
module fuse_prog_model (
	input wire clk_i,
	output reg prog_o = 1'b0,
	output reg serial_o = 1'b0,
	output reg [2:0] req_o = 3'h0,
	output reg [1:0] sel_o = 2'h0,
	output reg [7:0] data_o = 8'h00
);
	task mode(input p, input s);
	begin
		@(posedge clk_i);
		prog_o <= p;
		serial_o <= s;
	end
	endtask
	// kind is {fuse write, lock write, erase}; callers set one kind bit per op
	task op(input [2:0] kind, input [1:0] sel, input [7:0] data);
	begin
		@(posedge clk_i);
		req_o <= kind;
		sel_o <= sel;
		data_o <= data;
		@(posedge clk_i);
		req_o <= 3'h0;
		data_o <= ~data;
	end
	endtask
endmodule // fuse_prog_model

// ===== bench/fuse_cfg_checker.sv
// assertions on the fuse, identity and trim block ports
`timescale 1ns/1ns
module fuse_cfg_checker #(
	parameter [7:0] TRIM_BYTE = 8'h80,
	parameter [7:0] ID_BYTE_0 = 8'h5a,
	parameter FLASH_WORD_BITS = 5,
	parameter PC_TOP = 11
) (
	input wire clk_i, reset_n_i, prog_mode_i, chip_erase_i, id_read_i,
	input wire [1:0] id_addr_i,
	input wire [PC_TOP:0] prog_counter_i,
	input wire [7:0] id_data_o, oscillator_trim_register_o,
	input wire [7:0] extended_config_fuses_o, low_config_fuses_o,
	input wire watchdog_forced_on_o, watchdog_irq_allow_o, eeprom_keep_on_erase_o,
	input wire erase_eeprom_o,
	input wire [FLASH_WORD_BITS-1:0] word_in_page_index_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);
	trim_load_a: assert property ($rose(reset_n_i) |-> oscillator_trim_register_o == TRIM_BYTE)
		else $error("trim not loaded");
	trim_hold_a: assert property ($past(reset_n_i) |-> $stable(oscillator_trim_register_o))
		else $error("trim moved");
	id_zero_a: assert property (id_read_i && id_addr_i == 2'h0 |=> id_data_o == ID_BYTE_0)
		else $error("id byte wrong");
	ext_ones_a: assert property (extended_config_fuses_o[7:1] == 7'h7f)
		else $error("ext unused bits");
	wdog_irq_a: assert property (watchdog_irq_allow_o == !watchdog_forced_on_o)
		else $error("irq allow wrong");
	latch_hold_a: assert property (prog_mode_i [*4] |-> $stable(low_config_fuses_o))
		else $error("fuses moved");
	erase_keep_a: assert property (chip_erase_i && prog_mode_i |-> erase_eeprom_o == !eeprom_keep_on_erase_o)
		else $error("eeprom erase wrong");
	word_split_a: assert property (word_in_page_index_o == prog_counter_i[FLASH_WORD_BITS-1:0])
		else $error("word index wrong");
	cover property (chip_erase_i && eeprom_keep_on_erase_o);
	cover property (prog_mode_i [*4]);
	cover property (id_read_i && id_addr_i == 2'h2);
endmodule // fuse_cfg_checker
bind fuse_signature_config fuse_cfg_checker #(.TRIM_BYTE(TRIM_BYTE), .ID_BYTE_0(ID_BYTE_0),
	.FLASH_WORD_BITS(FLASH_WORD_BITS), .PC_TOP(PC_TOP)) u_chk (.clk_i, .reset_n_i, .prog_mode_i,
	.chip_erase_i, .id_read_i, .id_addr_i, .prog_counter_i, .id_data_o, .oscillator_trim_register_o,
	.extended_config_fuses_o, .low_config_fuses_o, .watchdog_forced_on_o, .watchdog_irq_allow_o,
	.eeprom_keep_on_erase_o, .erase_eeprom_o, .word_in_page_index_o);

// ===== bench/test_fuse_signature_config.sv
// self-checking bench for the fuse, identity and trim block
`timescale 1ns/1ns
module test_fuse_signature_config;
	reg clk_i = 1'b0, reset_n_i = 1'b0, id_read_i = 1'b0;
	reg [1:0] read_sel_i = 2'h0, id_addr_i = 2'h0;
	reg [11:0] prog_counter_i = 12'h000;
	reg [8:0] eeprom_byte_address_i = 9'h000;
	wire prog_mode_i, serial_port_i, fuse_write_i, lock_write_i, chip_erase_i, self_write_allow_o;
	wire reset_pin_off_o, debug_link_on_o, serial_prog_allow_o, watchdog_forced_on_o, clock_pin_o;
	wire watchdog_irq_allow_o, eeprom_keep_on_erase_o, clock_divide_eight_o, clock_pin_output_o;
	wire erase_eeprom_o, erase_flash_o;
	wire [1:0] fuse_sel_i, lock_data_i, startup_delay_select_o, eeprom_word_index_o;
	wire [2:0] brownout_threshold_o;
	wire [3:0] clock_source_select_o;
	wire [4:0] word_in_page_index_o;
	wire [6:0] page_index_o, eeprom_page_index_o;
	wire [7:0] fuse_data_i, read_data_o, id_data_o, oscillator_trim_register_o, erase_fill_o;
	wire [7:0] extended_config_fuses_o, high_config_fuses_o, low_config_fuses_o;
	wire [7:0] flags = {self_write_allow_o, reset_pin_off_o, debug_link_on_o, serial_prog_allow_o,
		watchdog_forced_on_o, eeprom_keep_on_erase_o, clock_divide_eight_o, clock_pin_output_o};
	integer err_count = 0, comparisons = 0, i;
	fuse_prog_model u_prog (.clk_i, .prog_o(prog_mode_i), .serial_o(serial_port_i),
		.req_o({fuse_write_i, lock_write_i, chip_erase_i}), .sel_o(fuse_sel_i), .data_o(fuse_data_i));
	assign lock_data_i = fuse_data_i[1:0];
	fuse_signature_config u_dut (.*);
	initial
		forever #2 clk_i = ~clk_i;
	task chk(input [15:0] seen, input [15:0] want);
	begin
		comparisons = comparisons + 1;
		if (seen !== want)
		begin
			err_count = err_count + 1;
			$display("BAD %0t seen %h want %h", $time, seen, want);
		end
	end
	endtask
	task rd(input [1:0] s);
	begin
		@(posedge clk_i);
		read_sel_i <= s;
		repeat (2) @(posedge clk_i);
		#1;
	end
	endtask
	task t_defaults;
	begin
		chk({extended_config_fuses_o, high_config_fuses_o}, 16'hffdf);
		chk({low_config_fuses_o, clock_source_select_o}, 12'h622);
		chk(flags, 8'h12);
		chk(oscillator_trim_register_o, 8'h80);
	end
	endtask
	task t_fuses;
	begin
		u_prog.mode(1'b1, 1'b1);
		u_prog.op(3'h4, 2'h1, 8'hff);
		rd(2'h1);
		chk(read_data_o, 8'hdf);
		u_prog.mode(1'b1, 1'b0);
		u_prog.op(3'h4, 2'h1, 8'hc7);
		rd(2'h1);
		chk(read_data_o, 8'hc7);
		chk({eeprom_keep_on_erase_o, watchdog_forced_on_o}, 2'h2);
		u_prog.op(3'h4, 2'h0, 8'h00);
		u_prog.op(3'h4, 2'h2, 8'h22);
		fork
			u_prog.op(3'h1, 2'h0, 8'h00);
			begin
				@(posedge clk_i);
				#1 chk({erase_flash_o, erase_eeprom_o, erase_fill_o}, 10'h2ff);
			end
		join
		rd(2'h0);
		chk(read_data_o, 8'hfe);
		u_prog.mode(1'b0, 1'b0);
		rd(2'h2);
		chk({high_config_fuses_o, low_config_fuses_o}, 16'hc722);
		chk({watchdog_irq_allow_o, clock_pin_output_o, clock_pin_o}, 3'h3);
	end
	endtask
	task t_lock;
	begin
		u_prog.mode(1'b1, 1'b0);
		u_prog.op(3'h2, 2'h0, 8'h02);
		u_prog.op(3'h4, 2'h2, 8'hff);
		rd(2'h2);
		chk(read_data_o, 8'h22);
		chk({reset_pin_off_o, debug_link_on_o}, 2'h0);
		for (i = 0; i < 3; i = i + 1)
		begin
			@(posedge clk_i);
			id_read_i <= 1'b1;
			id_addr_i <= i[1:0];
			@(posedge clk_i);
			#1 chk(id_data_o, (24'h5a0102 >> (8 * (2 - i))) & 24'hff);
		end
		u_prog.mode(1'b0, 1'b0);
	end
	endtask
	task t_split;
	begin
		@(posedge clk_i);
		prog_counter_i <= 12'habc;
		eeprom_byte_address_i <= 9'h1a7;
		#1 chk({word_in_page_index_o, page_index_o}, {5'h1c, 7'h55});
		chk({eeprom_word_index_o, eeprom_page_index_o}, {2'h3, 7'h69});
	end
	endtask
	task t_rerun;
	begin
		@(posedge clk_i);
		reset_n_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		reset_n_i <= 1'b1;
		@(posedge clk_i);
		#1 chk({high_config_fuses_o, oscillator_trim_register_o}, 16'hc780);
	end
	endtask
	task finish_test;
	begin
		$display("errors %0d of %0d checks", err_count, comparisons);
		if (err_count == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	end
	endtask
	initial
	begin
		#4000;
		err_count = err_count + 1;
		finish_test;
	end
	initial
	begin
		repeat (2) @(posedge clk_i);
		reset_n_i <= 1'b1;
		@(posedge clk_i);
		#1 t_defaults;
		t_fuses;
		t_lock;
		t_split;
		t_rerun;
		finish_test;
	end
endmodule // test_fuse_signature_config
